// file: rtl/mss_pkg.sv
// state type of the speed sequencer
package mss_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXT_RUN,
		ST_PROG_RUN,
		ST_PROG_GAP,
		ST_DRAFT,
		ST_DRAFT_HOLD,
		ST_TRAVERSE
	} mss_state_e;
endpackage

// file: rtl/mss_regs.svh
// register map, field codes, reset values and timing of the speed sequencer
// What this block does
// - mode 0 normal, 1 program, 2 external four
// - mode 3 picks speed from four select pins
// - four select pins form select bits zero-three
// - binary index n selects preset frequency n+1
// - all selects off gives main frequency
// - keypad source uses keypad preset as main
// - external mode takes ramp, direction from pins
// - mode 4 starts draft on trigger input
// - draft lasts first segment timer times ten
// - after draft: third preset, output on, stop clears
// - traverse running ignores all but stop commands
// - traverse uses keypad, second, eighth presets, timers
// - run pattern: once, loop, once-gapped, loop-gapped
// - run pattern matters only in mode 1
// - single cycle stops itself, restarts on run
// - looping repeats, only stop commands accepted
// - gapped patterns stop between segments, then restart
// - segment frequency from presets, time from timers
// - zero timer segments skipped, internal direction only
// - two eight-bit direction masks, bit per segment
// - two-bit ramp code selects ramp pair one-four
// - ramp codes packed two bits per segment
// - masks and ramp codes apply only mode 1
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH

`define MSS_OFF_MODE        8'h00
`define MSS_OFF_PATTERN     8'h04
`define MSS_OFF_DIR_FIRST   8'h08
`define MSS_OFF_DIR_LAST    8'h0c
`define MSS_OFF_RAMP_FIRST  8'h10
`define MSS_OFF_RAMP_LAST   8'h14
`define MSS_OFF_MAIN_SRC    8'h18
`define MSS_OFF_KEYPAD      8'h1c
`define MSS_OFF_STATUS      8'h24
`define MSS_OFF_PRESET_BASE 8'h40
`define MSS_OFF_TIMER_BASE  8'h80
`define MSS_TABLE_MASK      8'hc0

`define MSS_MODE_NORMAL     3'h0
`define MSS_MODE_PROGRAM    3'h1
`define MSS_MODE_EXT4       3'h2
`define MSS_MODE_EXT16      3'h3
`define MSS_MODE_DRAFT      3'h4
`define MSS_MODE_TRAVERSE   3'h5

`define MSS_PAT_ONCE        2'h0
`define MSS_PAT_LOOP        2'h1
`define MSS_PAT_ONCE_GAP    2'h2
`define MSS_PAT_LOOP_GAP    2'h3

`define MSS_RST_MODE        3'h2
`define MSS_RST_PATTERN     2'h0
`define MSS_RST_DIR         8'h00
`define MSS_RST_RAMP        16'h0000
`define MSS_SRC_KEYPAD      2'h0
// entry 0 is the keypad preset, entries 1-15 presets two-sixteen, 0.01 Hz
`define MSS_PRESET_RESET    256'h1194_0fa0_0dac_0bb8_09c4_07d0_05dc_03e8_0032_0fa0_0dac_0bb8_09c4_07d0_05dc_1388
// 0.1 s units, first two segment timers at 10.0 s
`define MSS_TIMER_RESET     256'h0064_0064

`define MSS_IDX_KEYPAD      4'h0
`define MSS_IDX_PRESET2     4'h1
`define MSS_IDX_PRESET3     4'h2
`define MSS_IDX_PRESET8     4'h7
`define MSS_SEG_FIRST       4'h0
`define MSS_SEG_SECOND      4'h1
`define MSS_DRAFT_SCALE     20'h0000a

`define MSS_SEG_TICK_NS     100000000
`define MSS_CLK_PERIOD_NS   4

`endif

// file: rtl/mss_speed_sequencer.sv
// multi-segment speed sequencer: preset selection, program run, draft, traverse
`timescale 1ns/1ps
`include "mss_regs.svh"

module mss_speed_sequencer #(
	parameter int TICK_CYCLES = `MSS_SEG_TICK_NS / `MSS_CLK_PERIOD_NS,
	parameter int GAP_TICKS   = 1
) (
	input  wire logic        clk,          // 250 MHz control clock
	input  wire logic        reset_n,      // async reset, active low
	input  wire logic [7:0]  regAddr,      // register byte address
	input  wire logic [31:0] regWrData,    // register write data
	input  wire logic        regWr,        // write strobe
	input  wire logic        regRd,        // read strobe
	output logic      [31:0] regRdData,    // read data, cycle after strobe
	input  wire logic [15:0] mainFreqIn,   // main frequency, non-keypad
	input  wire logic [3:0]  segSelPin,    // segment select bits 0-3
	input  wire logic        extDirPin,    // external reverse request
	input  wire logic [1:0]  extRampPin,   // external ramp pair choice
	input  wire logic        runPin,       // run command
	input  wire logic        stopPin,      // stop command
	input  wire logic        extFaultPin,  // external fault
	input  wire logic        eStopPin,     // emergency stop
	input  wire logic        draftTrigPin, // draft start trigger
	output logic      [15:0] freqRef,      // frequency reference, 0.01 Hz
	output logic             dirReverse,   // 1 = reverse rotation
	output logic      [1:0]  rampSel,      // ramp pair 0-3
	output logic             running,      // sequence active
	output logic      [3:0]  segIndex,     // current segment
	output logic             draftOut      // draft-done contact
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [255:0] PRESET_INIT = `MSS_PRESET_RESET;
	localparam logic [255:0] TIMER_INIT  = `MSS_TIMER_RESET;
	localparam logic [19:0]  GAP_LOAD    = 20'(GAP_TICKS);

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [2:0]  speedMode;
	logic [1:0]  runPattern;
	logic [7:0]  dirFirst;
	logic [7:0]  dirLast;
	logic [15:0] rampFirst;
	logic [15:0] rampLast;
	logic [1:0]  mainSource;
	logic [15:0] presetFreq [16];
	logic [15:0] segTimer   [16];

	wire logic tableHit  = regWr &&
		((regAddr & `MSS_TABLE_MASK) == `MSS_OFF_PRESET_BASE);
	wire logic timerHit  = regWr &&
		((regAddr & `MSS_TABLE_MASK) == `MSS_OFF_TIMER_BASE);
	wire logic keypadHit = regWr && (regAddr == `MSS_OFF_KEYPAD);
	wire logic [3:0] tableIdx = regAddr[5:2];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			speedMode  <= `MSS_RST_MODE;
			runPattern <= `MSS_RST_PATTERN;
			dirFirst   <= `MSS_RST_DIR;
			dirLast    <= `MSS_RST_DIR;
			rampFirst  <= `MSS_RST_RAMP;
			rampLast   <= `MSS_RST_RAMP;
			mainSource <= `MSS_SRC_KEYPAD;
		end else if (regWr) begin
			case (regAddr)
				`MSS_OFF_MODE:       speedMode  <= regWrData[2:0];
				`MSS_OFF_PATTERN:    runPattern <= regWrData[1:0];
				`MSS_OFF_DIR_FIRST:  dirFirst   <= regWrData[7:0];
				`MSS_OFF_DIR_LAST:   dirLast    <= regWrData[7:0];
				`MSS_OFF_RAMP_FIRST: rampFirst  <= regWrData[15:0];
				`MSS_OFF_RAMP_LAST:  rampLast   <= regWrData[15:0];
				`MSS_OFF_MAIN_SRC:   mainSource <= regWrData[1:0];
				default: ;
			endcase
		end
	end

	// keypad preset doubles as table entry 0 so segment one reads it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				presetFreq[i] <= PRESET_INIT[i*16 +: 16];
			end
		end else if (keypadHit) begin
			presetFreq[`MSS_IDX_KEYPAD] <= regWrData[15:0];
		end else if (tableHit) begin
			presetFreq[tableIdx] <= regWrData[15:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 16; i++) begin
				segTimer[i] <= TIMER_INIT[i*16 +: 16];
			end
		end else if (timerHit) begin
			segTimer[tableIdx] <= regWrData[15:0];
		end
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [11:0] pinMeta;
	logic [11:0] pinSync;
	logic        runPrev;
	logic        draftPrev;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta <= 12'h000;
			pinSync <= 12'h000;
		end else begin
			pinMeta <= {draftTrigPin, eStopPin, extFaultPin, stopPin,
				runPin, extRampPin, extDirPin, segSelPin};
			pinSync <= pinMeta;
		end
	end

	wire logic [3:0] segSel   = pinSync[3:0];
	wire logic       extDir   = pinSync[4];
	wire logic [1:0] extRamp  = pinSync[6:5];
	wire logic       runLvl   = pinSync[7];
	wire logic       anyStop  = pinSync[8] | pinSync[9] | pinSync[10];
	wire logic       hardStop = pinSync[9] | pinSync[10];
	wire logic       draftLvl = pinSync[11];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			runPrev   <= 1'b0;
			draftPrev <= 1'b0;
		end else begin
			runPrev   <= runLvl;
			draftPrev <= draftLvl;
		end
	end

	wire logic runEdge   = runLvl & ~runPrev;
	wire logic draftEdge = draftLvl & ~draftPrev;
	wire logic stopAny   = anyStop | hardStop;

	// ************************************************************
	// helpers
	// ************************************************************
	// first non-zero timer at or after start: {found, wrapped, index}
	function automatic logic [5:0] findSeg(input logic [4:0] start);
		logic [4:0] p;
		findSeg = 6'h00;
		for (int i = 15; i >= 0; i--) begin
			p = start + 5'(i);
			if (segTimer[p[3:0]] != 16'h0000) begin
				findSeg = {1'b1, p[4], p[3:0]};
			end
		end
	endfunction

	function automatic logic segDir(input logic [3:0] k);
		segDir = k[3] ? dirLast[k[2:0]] : dirFirst[k[2:0]];
	endfunction

	function automatic logic [1:0] segRamp(input logic [3:0] k);
		logic [15:0] w;
		w = k[3] ? rampLast : rampFirst;
		segRamp = w[{k[2:0], 1'b0} +: 2];
	endfunction

	wire logic [15:0] mainFreq = (mainSource == `MSS_SRC_KEYPAD) ?
		presetFreq[`MSS_IDX_KEYPAD] : mainFreqIn;

	// ************************************************************
	// segment tick
	// ************************************************************
	mss_pkg::mss_state_e state;
	logic [TICK_W-1:0]  tickCnt;
	logic               tick;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCnt <= '0;
			tick    <= 1'b0;
		end else if (state == mss_pkg::ST_IDLE) begin
			tickCnt <= '0;
			tick    <= 1'b0;
		end else if (tickCnt == TICK_W'(TICK_CYCLES - 1)) begin
			tickCnt <= '0;
			tick    <= 1'b1;
		end else begin
			tickCnt <= tickCnt + 1'b1;
			tick    <= 1'b0;
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	logic [3:0]  seg;
	logic [3:0]  pendSeg;
	logic [19:0] cnt;
	logic        phase;
	logic        hopNow;
	logic [5:0]  found;
	logic [5:0]  first;

	always_comb begin
		found = findSeg({1'b0, seg} + 5'h01);
		first = findSeg(5'h00);
	end

	wire logic cntDone = (cnt <= 20'h00001);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state   <= mss_pkg::ST_IDLE;
			seg     <= `MSS_SEG_FIRST;
			pendSeg <= `MSS_SEG_FIRST;
			cnt     <= 20'h00000;
			phase   <= 1'b0;
			hopNow  <= 1'b0;
		end else if (state != mss_pkg::ST_IDLE && stopAny) begin
			state  <= mss_pkg::ST_IDLE;
			hopNow <= 1'b0;
		end else begin
			case (state)
				mss_pkg::ST_IDLE: begin
					if (speedMode == `MSS_MODE_PROGRAM && runEdge) begin
						if (first[5]) begin
							seg   <= first[3:0];
							cnt   <= {4'h0, segTimer[first[3:0]]};
							state <= mss_pkg::ST_PROG_RUN;
						end
					end else if (speedMode == `MSS_MODE_DRAFT) begin
						if (draftEdge) begin
							cnt   <= {4'h0, segTimer[`MSS_SEG_FIRST]} *
								`MSS_DRAFT_SCALE;
							state <= mss_pkg::ST_DRAFT;
						end
					end else if (speedMode == `MSS_MODE_TRAVERSE) begin
						if (runEdge) begin
							phase  <= 1'b0;
							hopNow <= 1'b1;
							cnt    <= {4'h0, segTimer[`MSS_SEG_FIRST]};
							state  <= mss_pkg::ST_TRAVERSE;
						end
					end else if (runEdge) begin
						state <= mss_pkg::ST_EXT_RUN;
					end
				end
				mss_pkg::ST_PROG_RUN: begin
					if (tick) begin
						if (!cntDone) begin
							cnt <= cnt - 20'h00001;
						end else if (!found[5] ||
							(found[4] && !runPattern[0])) begin
							state <= mss_pkg::ST_IDLE;
						end else if (runPattern[1]) begin
							pendSeg <= found[3:0];
							cnt     <= GAP_LOAD;
							state   <= mss_pkg::ST_PROG_GAP;
						end else begin
							seg <= found[3:0];
							cnt <= {4'h0, segTimer[found[3:0]]};
						end
					end
				end
				mss_pkg::ST_PROG_GAP: begin
					if (tick) begin
						if (cntDone) begin
							seg   <= pendSeg;
							cnt   <= {4'h0, segTimer[pendSeg]};
							state <= mss_pkg::ST_PROG_RUN;
						end else begin
							cnt <= cnt - 20'h00001;
						end
					end
				end
				mss_pkg::ST_DRAFT: begin
					if (cnt == 20'h00000 || (tick && cntDone)) begin
						state <= mss_pkg::ST_DRAFT_HOLD;
					end else if (tick) begin
						cnt <= cnt - 20'h00001;
					end
				end
				mss_pkg::ST_DRAFT_HOLD: begin
					state <= mss_pkg::ST_DRAFT_HOLD;
				end
				mss_pkg::ST_TRAVERSE: begin
					if (tick) begin
						hopNow <= 1'b0;
						if (cntDone) begin
							phase  <= ~phase;
							hopNow <= 1'b1;
							cnt    <= {4'h0, phase ?
								segTimer[`MSS_SEG_FIRST] :
								segTimer[`MSS_SEG_SECOND]};
						end else begin
							cnt <= cnt - 20'h00001;
						end
					end
				end
				mss_pkg::ST_EXT_RUN: begin
					state <= mss_pkg::ST_EXT_RUN;
				end
				default: state <= mss_pkg::ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// output selection
	// ************************************************************
	logic [15:0] next_freqRef;
	logic        next_dirReverse;
	logic [1:0]  next_rampSel;
	logic        next_running;
	logic        next_draftOut;
	logic [3:0]  extIdx;
	logic [16:0] hopSum;

	always_comb begin
		next_freqRef    = 16'h0000;
		next_dirReverse = 1'b0;
		next_rampSel    = 2'h0;
		next_running    = 1'b1;
		next_draftOut   = 1'b0;
		extIdx          = (speedMode == `MSS_MODE_EXT4) ?
			{2'h0, segSel[1:0]} : segSel;
		hopSum = {1'b0, phase ? presetFreq[`MSS_IDX_PRESET2] :
			presetFreq[`MSS_IDX_KEYPAD]} +
			{1'b0, presetFreq[`MSS_IDX_PRESET8]};
		case (state)
			mss_pkg::ST_IDLE: begin
				next_running = 1'b0;
			end
			mss_pkg::ST_EXT_RUN: begin
				next_freqRef = (extIdx == `MSS_IDX_KEYPAD) ? mainFreq :
					presetFreq[extIdx];
				next_dirReverse = extDir;
				next_rampSel    = extRamp;
			end
			mss_pkg::ST_PROG_RUN: begin
				next_freqRef    = presetFreq[seg];
				next_dirReverse = segDir(seg);
				next_rampSel    = segRamp(seg);
			end
			mss_pkg::ST_PROG_GAP: begin
				next_dirReverse = segDir(pendSeg);
				next_rampSel    = segRamp(pendSeg);
			end
			mss_pkg::ST_DRAFT: begin
				next_freqRef = mainFreq;
			end
			mss_pkg::ST_DRAFT_HOLD: begin
				next_freqRef  = presetFreq[`MSS_IDX_PRESET3];
				next_draftOut = 1'b1;
			end
			mss_pkg::ST_TRAVERSE: begin
				if (hopNow) begin
					next_freqRef = hopSum[16] ? 16'hffff : hopSum[15:0];
				end else begin
					next_freqRef = hopSum[15:0] -
						presetFreq[`MSS_IDX_PRESET8];
				end
			end
			default: begin
				next_running = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			freqRef    <= 16'h0000;
			dirReverse <= 1'b0;
			rampSel    <= 2'h0;
			running    <= 1'b0;
			draftOut   <= 1'b0;
			segIndex   <= 4'h0;
		end else begin
			freqRef    <= next_freqRef;
			dirReverse <= next_dirReverse;
			rampSel    <= next_rampSel;
			running    <= next_running;
			draftOut   <= next_draftOut;
			segIndex   <= seg;
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= 32'h00000000;
		end else if (!regRd) begin
			regRdData <= 32'h00000000;
		end else if ((regAddr & `MSS_TABLE_MASK) ==
			`MSS_OFF_PRESET_BASE) begin
			regRdData <= {16'h0000, presetFreq[tableIdx]};
		end else if ((regAddr & `MSS_TABLE_MASK) ==
			`MSS_OFF_TIMER_BASE) begin
			regRdData <= {16'h0000, segTimer[tableIdx]};
		end else begin
			case (regAddr)
				`MSS_OFF_MODE:       regRdData <= {29'h0, speedMode};
				`MSS_OFF_PATTERN:    regRdData <= {30'h0, runPattern};
				`MSS_OFF_DIR_FIRST:  regRdData <= {24'h0, dirFirst};
				`MSS_OFF_DIR_LAST:   regRdData <= {24'h0, dirLast};
				`MSS_OFF_RAMP_FIRST: regRdData <= {16'h0, rampFirst};
				`MSS_OFF_RAMP_LAST:  regRdData <= {16'h0, rampLast};
				`MSS_OFF_MAIN_SRC:   regRdData <= {30'h0, mainSource};
				`MSS_OFF_KEYPAD:
					regRdData <= {16'h0, presetFreq[`MSS_IDX_KEYPAD]};
				`MSS_OFF_STATUS:
					regRdData <= {freqRef, 2'h0, segIndex, 1'b0,
						state, 1'b0, draftOut, rampSel, dirReverse,
						running};
				default: regRdData <= 32'h00000000;
			endcase
		end
	end

endmodule

// file: verification/mss_speed_sequencer_properties.sv
// port checker of the multi-segment speed sequencer
`timescale 1ns/1ps
module mss_speed_sequencer_properties (
	input wire logic        clk,          // control clock
	input wire logic        reset_n,      // async reset, active low
	input wire logic [7:0]  regAddr,      // register address
	input wire logic        regRd,        // read strobe
	input wire logic [31:0] regRdData,    // read data
	input wire logic        runPin,       // run command
	input wire logic        stopPin,      // stop command
	input wire logic        extFaultPin,  // external fault
	input wire logic        eStopPin,     // emergency stop
	input wire logic        draftTrigPin, // draft trigger
	input wire logic [15:0] freqRef,      // frequency reference
	input wire logic        dirReverse,   // reverse rotation
	input wire logic        running,      // sequence active
	input wire logic        draftOut      // draft-done contact
);
	// ****************************************************************
	// helper: cycles since the last start command
	// ****************************************************************
	logic [3:0] sinceCmd;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sinceCmd <= 4'hf;
		else if (runPin || draftTrigPin)
			sinceCmd <= 4'h0;
		else if (sinceCmd != 4'hf)
			sinceCmd <= sinceCmd + 4'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_RD_IDLE_ZERO: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data not zero outside read cycle");
	AST_RD_UNMAPPED: assert property (regRd && regAddr == 8'h30 |=>
		regRdData == 32'h0) else $error("unmapped read not zero");
	AST_RD_UPPER_ZERO: assert property (regRd && regAddr != 8'h24 |=>
		regRdData[31:16] == 16'h0) else $error("upper read bits set");
	AST_STOP_WINS: assert property (stopPin [*5] |-> !running)
		else $error("still running under stop");
	AST_FAULT_WINS: assert property (extFaultPin [*5] |-> !running)
		else $error("still running under fault");
	AST_ESTOP_WINS: assert property (eStopPin [*5] |-> !running)
		else $error("still running under emergency stop");
	AST_IDLE_QUIET: assert property (!running |-> freqRef == 16'h0
		&& !draftOut) else $error("output active while idle");
	AST_DRAFT_OUT_RUN: assert property (draftOut |-> running &&
		!dirReverse) else $error("draft contact without draft run");
	AST_START_CAUSE: assert property ($rose(running) |->
		sinceCmd <= 4'h8) else $error("start without command");

	COV_DRAFT: cover property ($rose(draftOut));
	COV_REVERSE: cover property (running && dirReverse);
	COV_GAP: cover property (running && freqRef == 16'h0);
endmodule

// file: verification/mss_switch_panel.sv
// switch and contact model driving the sequencer's digital inputs
`timescale 1ns/1ps
module mss_switch_panel (
	input  wire logic clk,          // control clock
	output logic [3:0] segSelPin,   // select bits 0-3
	output logic       extDirPin,   // reverse switch
	output logic [1:0] extRampPin,  // ramp pair switches
	output logic       runPin,      // run push-button
	output logic       stopPin,     // stop push-button
	output logic       extFaultPin, // fault contact
	output logic       eStopPin,    // emergency stop contact
	output logic       draftTrigPin // draft trigger contact
);
	initial begin
		{segSelPin, extDirPin, extRampPin} = 7'h0;
		{runPin, stopPin, extFaultPin, eStopPin, draftTrigPin} = 5'h0;
	end

	// open contacts read low through the input pull-down
	task automatic press(input int which, input int len);
		@(posedge clk);
		case (which)
			0: runPin <= 1'b1;
			1: stopPin <= 1'b1;
			2: extFaultPin <= 1'b1;
			3: eStopPin <= 1'b1;
			default: draftTrigPin <= 1'b1;
		endcase
		repeat (len) @(posedge clk);
		{runPin, stopPin, extFaultPin, eStopPin, draftTrigPin} <= 5'h0;
	endtask

	task automatic set_levels(input logic [3:0] sel, input logic dir,
		input logic [1:0] ramp);
		@(posedge clk);
		segSelPin <= sel;
		extDirPin <= dir;
		extRampPin <= ramp;
	endtask
endmodule

// file: verification/multi_segment_speed_sequencer_bench.sv
// self-checking bench of the multi-segment speed sequencer
`timescale 1ns/1ps
`include "mss_regs.svh"
module multi_segment_speed_sequencer_bench;
	localparam int TICK = 4;
	localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0c,
		8'h10, 8'h14, 8'h18, 8'h48, 8'h5c, 8'h80, 8'h88};
	localparam logic [31:0] RV [11] = '{32'h2, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h7d0, 32'h32, 32'h64, 32'h0};
	logic        clk, reset_n, regWr, regRd, extDirPin, runPin, stopPin;
	logic        extFaultPin, eStopPin, draftTrigPin, dirReverse, running;
	logic        draftOut, sawSkip, sawGap;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData, d;
	logic [15:0] mainFreqIn, freqRef;
	logic [3:0]  segSelPin, segIndex;
	logic [1:0]  extRampPin, rampSel;
	int          errors, n_checks, i, n, sawKey, sawTwo;

	mss_speed_sequencer #(.TICK_CYCLES(TICK), .GAP_TICKS(1)) u_dut (
		.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .mainFreqIn(mainFreqIn),
		.segSelPin(segSelPin), .extDirPin(extDirPin),
		.extRampPin(extRampPin), .runPin(runPin), .stopPin(stopPin),
		.extFaultPin(extFaultPin), .eStopPin(eStopPin),
		.draftTrigPin(draftTrigPin), .freqRef(freqRef),
		.dirReverse(dirReverse), .rampSel(rampSel), .running(running),
		.segIndex(segIndex), .draftOut(draftOut));

	mss_switch_panel u_panel (
		.clk(clk), .segSelPin(segSelPin), .extDirPin(extDirPin),
		.extRampPin(extRampPin), .runPin(runPin), .stopPin(stopPin),
		.extFaultPin(extFaultPin), .eStopPin(eStopPin),
		.draftTrigPin(draftTrigPin));

	// ****************************************************************
	// clock, monitors, watchdog
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		if (running === 1'b1 && segIndex === 4'h1)
			sawSkip <= 1'b1;
		if (running === 1'b1 && freqRef === 16'h0)
			sawGap <= 1'b1;
	end

	// whole run is under a thousand cycles; this is ample
	initial begin
		#200000;
		errors++;
		finish_test();
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdData;
	endtask

	function automatic logic cond(input int k);
		case (k)
			0: return running === 1'b1;
			1: return running === 1'b0;
			2: return segIndex === 4'h2;
			default: return draftOut === 1'b1;
		endcase
	endfunction

	// bounded wait; a miss shows up in the compare that follows
	task automatic wait_until(input int k, input int limit, output int c);
		for (c = 0; c < limit && !cond(k); c++) begin
			@(posedge clk);
			#1;
		end
	endtask

	function automatic logic [15:0] expf(input int idx);
		return (idx == 0) ? 16'h0050 : 16'(16'h0100 * idx);
	endfunction

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		{regAddr, regWrData, regWr, regRd} = 42'h0;
		mainFreqIn = 16'h1234;
		{errors, n_checks, sawSkip, sawGap} = 0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 11; i++) begin
			reg_read(RA[i], d);
			check(d, RV[i], "reset value");
		end
		reg_read(8'h30, d);
		check(d, 32'h0, "unmapped read");
		reg_write(`MSS_OFF_DIR_LAST, 32'hffff_ff5a);
		reg_read(`MSS_OFF_DIR_LAST, d);
		check(d, 32'h5a, "mask width");
		reg_write(`MSS_OFF_PATTERN, 32'h7);
		reg_read(`MSS_OFF_PATTERN, d);
		check(d, 32'h3, "pattern width");
		reg_write(`MSS_OFF_KEYPAD, 32'h50);
		for (i = 1; i < 16; i++)
			reg_write(8'h40 + 8'(4 * i), 32'(expf(i)));
		// program: seg one 2 ticks, seg two unused, seg three reversed
		reg_write(8'h80, 32'h2);
		reg_write(8'h84, 32'h0);
		reg_write(8'h88, 32'h3);
		reg_write(`MSS_OFF_DIR_FIRST, 32'h04);
		reg_write(`MSS_OFF_DIR_LAST, 32'h00);
		reg_write(`MSS_OFF_RAMP_FIRST, 32'h0030);
		reg_write(`MSS_OFF_PATTERN, 32'h0);
		reg_write(`MSS_OFF_MODE, 32'h1);
		u_panel.set_levels(4'h9, 1'b1, 2'h2);
		u_panel.press(0, 4);
		wait_until(0, 20, n);
		check({segIndex, freqRef, dirReverse}, {4'h0, 16'h50, 1'b0}, "seg1");
		wait_until(2, 100, n);
		check(freqRef, expf(2), "seg3 freq");
		check({dirReverse, rampSel}, 3'h7, "seg3 dir ramp");
		wait_until(1, 100, n);
		check(running, 1'b0, "single cycle end");
		repeat (60) @(posedge clk);
		check({running, sawSkip}, 2'h0, "no restart, skip");
		reg_write(`MSS_OFF_PATTERN, 32'h1);
		u_panel.press(0, 4);
		repeat (100) @(posedge clk);
		u_panel.press(0, 4);
		check(running, 1'b1, "loop keeps going");
		u_panel.press(2, 6);
		check(running, 1'b0, "fault stops loop");
		reg_write(`MSS_OFF_PATTERN, 32'h2);
		sawGap = 1'b0;
		u_panel.press(0, 4);
		wait_until(0, 20, n);
		wait_until(1, 200, n);
		check({running, sawGap}, 2'h1, "gapped cycle");
		// external sixteen-way: masks set but must be ignored
		reg_write(`MSS_OFF_DIR_FIRST, 32'hff);
		reg_write(`MSS_OFF_RAMP_FIRST, 32'hffff);
		reg_write(`MSS_OFF_PATTERN, 32'h3);
		reg_write(`MSS_OFF_MODE, 32'h3);
		u_panel.set_levels(4'h0, 1'b0, 2'h2);
		u_panel.press(0, 4);
		for (i = 0; i < 16; i++) begin
			u_panel.set_levels(4'(i), 1'b0, 2'h2);
			repeat (6) @(posedge clk);
			check(freqRef, expf(i), "select index");
		end
		check({dirReverse, rampSel}, 3'h2, "external dir ramp");
		u_panel.set_levels(4'h0, 1'b1, 2'h1);
		reg_write(`MSS_OFF_MAIN_SRC, 32'h1);
		repeat (6) @(posedge clk);
		check({freqRef, dirReverse, rampSel}, {16'h1234, 3'h5}, "main");
		u_panel.press(1, 6);
		check(running, 1'b0, "stop");
		// draft: one timer unit gives ten ticks
		reg_write(`MSS_OFF_MAIN_SRC, 32'h0);
		reg_write(8'h80, 32'h1);
		reg_write(`MSS_OFF_MODE, 32'h4);
		u_panel.set_levels(4'h0, 1'b0, 2'h0);
		repeat (20) @(posedge clk);
		check(running, 1'b0, "draft waits trigger");
		u_panel.press(4, 2);
		wait_until(0, 20, n);
		wait_until(3, 100, n);
		check(32'(n >= 10 * TICK - 8 && n <= 10 * TICK + 4), 32'h1, "draft time");
		check({running, freqRef}, {1'b1, expf(2)}, "draft hold");
		u_panel.press(1, 6);
		check({running, draftOut}, 2'h0, "draft stop");
		// traverse: keypad and preset two, hop from preset eight
		reg_write(8'h80, 32'h2);
		reg_write(8'h84, 32'h2);
		reg_write(`MSS_OFF_MODE, 32'h5);
		u_panel.press(0, 4);
		wait_until(0, 20, n);
		{sawKey, sawTwo} = 0;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			#1;
			sawKey += (freqRef === 16'h0050);
			sawTwo += (freqRef === 16'h0100);
			if (!(freqRef inside {16'h0050, 16'h0100, 16'h0750, 16'h0800}))
				check(freqRef, 16'h0050, "traverse freq");
		end
		check(32'(sawKey > 0 && sawTwo > 0), 32'h1, "traverse both");
		u_panel.set_levels(4'h7, 1'b1, 2'h3);
		u_panel.press(0, 4);
		check({running, dirReverse}, 2'h2, "traverse ignores");
		u_panel.press(3, 6);
		check(running, 1'b0, "emergency stop");
		finish_test();
	end
endmodule

bind mss_speed_sequencer mss_speed_sequencer_properties u_props (
	.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regRd(regRd),
	.regRdData(regRdData), .runPin(runPin), .stopPin(stopPin),
	.extFaultPin(extFaultPin), .eStopPin(eStopPin),
	.draftTrigPin(draftTrigPin), .freqRef(freqRef),
	.dirReverse(dirReverse), .running(running), .draftOut(draftOut));
